// >>> rtl/cwe_regs.vh
// constants for the control word engine: offsets, fields, codes
`ifndef CWE_REGS_VH
`define CWE_REGS_VH
`define CWE_R_CTRL   8'h00
`define CWE_R_MBX    8'h04
`define CWE_R_SCW    8'h08
`define CWE_R_STAT   8'h0c
`define CWE_R_TALLY  8'h10
`define CWE_C_START  0
`define CWE_C_IND    1
`define CWE_C_DIN    2
`define CWE_RST_CTRL 2'h0
`define CWE_RST_BASE 24'h000000
`define CWE_MB_LPWB  24'h000001
`define CWE_MB_DCWA  24'h000002
`define CWE_MB_DCWB  24'h000003
`define CWE_A_TYPE   35:33
`define CWE_A_TERM   32:30
`define CWE_A_EXH    29:27
`define CWE_A_EXT    26:24
`define CWE_A_INT    23:21
`define CWE_A_LSX    20
`define CWE_A_IPE    19
`define CWE_A_EDT    18
`define CWE_A_CTL    17:9
`define CWE_A_MODE   8
`define CWE_A_UCC    7
`define CWE_A_UINH   6
`define CWE_A_AEXT   5:0
`define CWE_B_ADR    35:18
`define CWE_B_TAL    17:6
`define CWE_B_SIZ    5:4
`define CWE_B_PAR    3
`define CWE_B_CP     2:0
`define CWE_T_MIC    3'h0
`define CWE_T_CTL    3'h1
`define CWE_T_TM     3'h2
`define CWE_T_CMD    3'h3
`define CWE_T_LIT    3'h4
`define CWE_S_W36    2'h0
`define CWE_S_C6     2'h1
`define CWE_S_C9     2'h2
`define CWE_EC_TERM  3'h1
`define CWE_EC_EXH   3'h2
`define CWE_EC_EXT   3'h3
`define CWE_EC_INT   3'h4
`define CWE_ONES     36'hfffffffff
`endif

// >>> rtl/cwe_engine.v
// data channel control word engine with status word storage
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cwe_regs.vh"
module cwe_engine (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        we_i,
   input  wire        re_i,
   output reg  [31:0] rdata_o,
   output reg         mem_req_o,
   output reg         mem_we_o,
   output reg  [23:0] mem_addr_o,
   output reg  [35:0] mem_wdata_o,
   output reg  [35:0] mem_mask_o,
   input  wire        mem_ack_i,
   input  wire [35:0] mem_rdata_i,
   input  wire        svc_req_i,
   input  wire [35:0] adp_data_i,
   input  wire        adp_perr_i,
   input  wire        adp_term_i,
   input  wire        adp_ext_i,
   output reg  [35:0] adp_data_o,
   output reg         adp_strobe_o,
   output reg         list_act_o,
   output reg         end_xfer_o,
   output reg         cmd_o,
   output reg  [8:0]  cmd_data_o,
   output reg         lit_o,
   output reg  [8:0]  lit_char_o,
   output reg         intr_o,
   output reg  [2:0]  intr_chan_o
);
   localparam S_IDLE = 5'h00, S_LRA = 5'h01, S_LRB = 5'h02;
   localparam S_DRA  = 5'h03, S_DRB = 5'h04, S_LWB = 5'h05;
   localparam S_MWA  = 5'h06, S_MWB = 5'h07, S_WAIT = 5'h08;
   localparam S_SRA  = 5'h09, S_SRB = 5'h0a, S_GO  = 5'h0b;
   localparam S_XRD  = 5'h0c, S_XWR = 5'h0d, S_XDN = 5'h0e;
   localparam S_EVT  = 5'h0f, S_SCB = 5'h10, S_STW = 5'h11;
   localparam S_SWB  = 5'h12, S_SCA = 5'h13, S_SRP = 5'h14;
   localparam S_SZA  = 5'h15, S_INT = 5'h16;

   reg  [4:0]  st_q;
   reg  [1:0]  ctrl_q;
   reg  [23:0] mbx_q;
   reg  [23:0] scw_q;
   reg  [35:0] la_q;
   reg  [35:0] lb_q;
   reg  [35:0] da_q;
   reg  [35:0] db_q;
   reg  [35:0] sb_q;
   reg  [35:0] sw_q;
   reg  [35:0] din_q;
   reg         perr_q;
   reg  [4:0]  ev_q;
   reg  [2:0]  ch_q;
   reg         busy_q;
   reg         done_q;
   reg         stop_q;
   reg         fetch_q;

   wire        ind   = ctrl_q[0];
   wire        dir_in = ctrl_q[1];
   wire        ack   = mem_req_o & mem_ack_i;
   wire [2:0]  typ   = da_q[`CWE_A_TYPE];
   wire [1:0]  siz   = db_q[`CWE_B_SIZ];
   wire [2:0]  cp    = db_q[`CWE_B_CP];
   wire [11:0] tal   = db_q[`CWE_B_TAL];
   wire        s6    = (siz == `CWE_S_C6);
   wire        chr   = (siz != `CWE_S_W36);
   wire [5:0]  sh6   = 6'h1e - {1'b0, cp, 2'b0} - {2'b0, cp, 1'b0};
   wire [5:0]  sh9   = 6'h1b - {cp, 3'b0} - {3'b0, cp};
   wire [5:0]  sh    = s6 ? sh6 : sh9;
   wire [35:0] lm    = s6 ? 36'h00000003f : 36'h0000001ff;
   wire [35:0] cmask = chr ? (lm << sh) : `CWE_ONES;
   wire [35:0] chin  = din_q & lm;
   wire [35:0] wdat  = chr ? (chin << sh) : din_q;
   wire        cp_last = s6 ? (cp == 3'h5) : (cp == 3'h3);
   wire [2:0]  cp_nx = (!chr | cp_last) ? 3'h0 : cp + 3'h1;
   wire        adr_inc = !chr | cp_last;
   wire [11:0] tal_nx = tal - 12'h001;
   wire        tz    = (tal_nx == 12'h000);
   wire [35:0] ctl36 = {27'h0, da_q[`CWE_A_CTL]} & lm;
   wire        match = (typ == `CWE_T_CTL) & chr & dir_in
                       & (chin == ctl36);
   wire        ucc   = (typ == `CWE_T_MIC) & da_q[`CWE_A_UCC] & chr
                       & dir_in & (chin[6:0] < 7'h20);
   wire        inh   = (typ == `CWE_T_MIC) & da_q[`CWE_A_UINH];
   wire        pe    = dir_in & perr_q;
   wire        par_nx = db_q[`CWE_B_PAR] | (pe & !da_q[`CWE_A_IPE]);
   wire        lit   = (typ == `CWE_T_LIT);
   // artificial exhaust from a match with mode zero
   wire        exh_now = tz | (match & !da_q[`CWE_A_MODE]);
   wire        edt   = da_q[`CWE_A_EDT];
   wire        xdn   = (st_q == S_XDN);
   wire        exh_ev = xdn & exh_now & !edt;
   wire        int_x = xdn & ((match & da_q[`CWE_A_MODE]) | ucc
                       | (pe & da_q[`CWE_A_IPE])
                       | (par_nx & exh_ev));
   wire        tm_hit = (typ == `CWE_T_TM) & mem_rdata_i[`CWE_B_TAL]
                       == {3'h0, da_q[`CWE_A_CTL]};
   wire        acc   = ack & ((st_q == S_DRB) | (st_q == S_SRB));
   wire        term  = busy_q & adp_term_i;
   wire        lsx_ev = busy_q & adp_ext_i & da_q[`CWE_A_LSX] & !adp_term_i;
   wire        lpw_z = (lb_q[`CWE_B_TAL] == 12'h001);
   wire [4:0]  ev_set;
   wire [4:0]  sel   = ev_q & (~ev_q + 5'h01);
   wire [4:0]  ev_clr = (st_q == S_EVT) ? sel : 5'h00;
   reg  [2:0]  ptr;
   reg  [2:0]  ec;

   // event order: terminate, exhaust, external, internal, list exhaust
   assign ev_set[0] = term;
   assign ev_set[1] = exh_ev;
   assign ev_set[2] = busy_q & adp_ext_i;
   assign ev_set[3] = int_x | (acc & tm_hit)
                      | (term & db_q[`CWE_B_PAR]);
   assign ev_set[4] = ack & (st_q == S_LWB) & lpw_z;

   always @* begin
      ptr = 3'h0;
      ec  = `CWE_EC_TERM;
      case (sel)
         5'h01: begin
            ptr = da_q[`CWE_A_TERM];
            ec  = `CWE_EC_TERM;
         end
         5'h02: begin
            ptr = da_q[`CWE_A_EXH];
            ec  = `CWE_EC_EXH;
         end
         5'h04: begin
            ptr = da_q[`CWE_A_EXT];
            ec  = `CWE_EC_EXT;
         end
         5'h08: begin
            ptr = da_q[`CWE_A_INT];
            ec  = `CWE_EC_INT;
         end
         5'h10: begin
            ptr = la_q[`CWE_A_EXH];
            ec  = `CWE_EC_EXH;
         end
         default: begin
            ptr = 3'h0;
            ec  = `CWE_EC_TERM;
         end
      endcase
   end

   task mop;
      input        w;
      input [23:0] a;
      input [35:0] d;
      input [35:0] m;
      begin
         mem_req_o   <= 1'b1;
         mem_we_o    <= w;
         mem_addr_o  <= a;
         mem_wdata_o <= d;
         mem_mask_o  <= m;
      end
   endtask

   always @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         ctrl_q <= `CWE_RST_CTRL;
         mbx_q <= `CWE_RST_BASE;
         scw_q <= `CWE_RST_BASE;
         la_q <= 36'h0;
         lb_q <= 36'h0;
         da_q <= 36'h0;
         db_q <= 36'h0;
         sb_q <= 36'h0;
         sw_q <= 36'h0;
         din_q <= 36'h0;
         perr_q <= 1'b0;
         ev_q <= 5'h00;
         ch_q <= 3'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         stop_q <= 1'b0;
         fetch_q <= 1'b0;
         rdata_o <= 32'h0;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 24'h0;
         mem_wdata_o <= 36'h0;
         mem_mask_o <= 36'h0;
         adp_data_o <= 36'h0;
         adp_strobe_o <= 1'b0;
         list_act_o <= 1'b0;
         end_xfer_o <= 1'b0;
         cmd_o <= 1'b0;
         cmd_data_o <= 9'h0;
         lit_o <= 1'b0;
         lit_char_o <= 9'h0;
         intr_o <= 1'b0;
         intr_chan_o <= 3'h0;
      end else if (ce_i) begin
         adp_strobe_o <= 1'b0;
         list_act_o <= 1'b0;
         end_xfer_o <= 1'b0;
         cmd_o <= 1'b0;
         lit_o <= 1'b0;
         intr_o <= 1'b0;
         rdata_o <= 32'h0;
         // a new event in the clearing cycle survives
         ev_q <= (ev_q & ~ev_clr) | ev_set;
         if (term)
            stop_q <= 1'b1;
         if (lsx_ev) begin
            list_act_o <= 1'b1;
            fetch_q <= 1'b1;
         end
         if (re_i) begin
            case (addr_i)
               `CWE_R_CTRL:  rdata_o <= {30'h0, ctrl_q};
               `CWE_R_MBX:   rdata_o <= {8'h0, mbx_q};
               `CWE_R_SCW:   rdata_o <= {8'h0, scw_q};
               `CWE_R_STAT:  rdata_o <= {18'h0, ev_q, st_q, fetch_q,
                                         stop_q, done_q, busy_q};
               `CWE_R_TALLY: rdata_o <= {17'h0, typ, tal};
               default:      rdata_o <= 32'h0;
            endcase
         end
         // configuration is locked while an operation runs
         if (we_i & !busy_q) begin
            case (addr_i)
               `CWE_R_CTRL: begin
                  ctrl_q <= wdata_i[`CWE_C_DIN:`CWE_C_IND];
                  if (wdata_i[`CWE_C_START]) begin
                     busy_q <= 1'b1;
                     done_q <= 1'b0;
                     stop_q <= 1'b0;
                     fetch_q <= 1'b0;
                     ev_q <= 5'h00;
                     st_q <= S_LRA;
                  end
               end
               `CWE_R_MBX: mbx_q <= wdata_i[23:0];
               `CWE_R_SCW: scw_q <= wdata_i[23:0];
               default: ;
            endcase
         end
         case (st_q)
            S_IDLE: ;
            S_LRA:
               if (!mem_req_o)
                  mop(1'b0, mbx_q, 36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  la_q <= mem_rdata_i;
                  st_q <= S_LRB;
               end
            S_LRB:
               if (!mem_req_o)
                  mop(1'b0, mbx_q + `CWE_MB_LPWB, 36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  lb_q <= mem_rdata_i;
                  // a list request arriving now must not be lost
                  fetch_q <= lsx_ev;
                  if (mem_rdata_i[`CWE_B_TAL] == 12'h000) begin
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     st_q <= S_IDLE;
                  end else
                     st_q <= S_DRA;
               end
            S_DRA:
               if (!mem_req_o)
                  mop(1'b0, {6'h0, lb_q[`CWE_B_ADR]}, 36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  da_q <= mem_rdata_i;
                  st_q <= S_DRB;
               end
            S_DRB:
               if (!mem_req_o)
                  mop(1'b0, {6'h0, lb_q[`CWE_B_ADR] + 18'h1}, 36'h0,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  db_q <= mem_rdata_i;
                  st_q <= S_LWB;
                  if (typ == `CWE_T_CMD) begin
                     cmd_o <= 1'b1;
                     cmd_data_o <= da_q[`CWE_A_CTL];
                     fetch_q <= 1'b1;
                  end
               end
            S_LWB:
               if (!mem_req_o)
                  mop(1'b1, mbx_q + `CWE_MB_LPWB,
                      {lb_q[`CWE_B_ADR] + 18'h2,
                       lb_q[`CWE_B_TAL] - 12'h001, lb_q[5:0]},
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= (ind | (typ == `CWE_T_CMD)) ? S_MWA : S_EVT;
               end
            S_MWA:
               if (!mem_req_o)
                  mop(1'b1, mbx_q + `CWE_MB_DCWA, da_q, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= S_MWB;
               end
            S_MWB:
               if (!mem_req_o)
                  mop(1'b1, mbx_q + `CWE_MB_DCWB, db_q,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= S_EVT;
               end
            S_WAIT:
               if ((ev_q != 5'h00) | fetch_q | stop_q)
                  st_q <= S_EVT;
               else if (svc_req_i) begin
                  din_q <= adp_data_i;
                  perr_q <= adp_perr_i;
                  st_q <= ind ? S_SRA : S_GO;
               end
            S_SRA:
               if (!mem_req_o)
                  mop(1'b0, mbx_q + `CWE_MB_DCWA, 36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  da_q <= mem_rdata_i;
                  st_q <= S_SRB;
               end
            S_SRB:
               if (!mem_req_o)
                  mop(1'b0, mbx_q + `CWE_MB_DCWB, 36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  db_q <= mem_rdata_i;
                  st_q <= S_GO;
               end
            S_GO:
               if (lit) begin
                  lit_o <= 1'b1;
                  lit_char_o <= da_q[`CWE_A_CTL];
                  st_q <= S_XDN;
               end else if (dir_in)
                  st_q <= inh ? S_XDN : S_XWR;
               else
                  st_q <= S_XRD;
            S_XRD:
               if (!mem_req_o)
                  mop(1'b0, {da_q[`CWE_A_AEXT], db_q[`CWE_B_ADR]},
                      36'h0, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  adp_data_o <= chr ? ((mem_rdata_i >> sh) & lm)
                                    : mem_rdata_i;
                  adp_strobe_o <= 1'b1;
                  st_q <= S_XDN;
               end
            S_XWR:
               if (!mem_req_o)
                  mop(1'b1, {da_q[`CWE_A_AEXT], db_q[`CWE_B_ADR]},
                      wdat, cmask);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  adp_strobe_o <= 1'b1;
                  st_q <= S_XDN;
               end
            S_XDN: begin
               // literal and inhibited moves keep the address
               db_q[`CWE_B_ADR] <= db_q[`CWE_B_ADR]
                  + {17'h0, adr_inc & !lit & !inh};
               db_q[`CWE_B_TAL] <= tal_nx;
               db_q[`CWE_B_CP] <= lit ? cp : cp_nx;
               db_q[`CWE_B_PAR] <= par_nx;
               if (exh_now & edt)
                  end_xfer_o <= 1'b1;
               if (exh_ev) begin
                  list_act_o <= 1'b1;
                  fetch_q <= 1'b1;
               end
               st_q <= ind ? S_MWB : S_EVT;
            end
            S_EVT:
               if (ev_q != 5'h00) begin
                  if (ptr != 3'h0) begin
                     ch_q <= ptr;
                     // full word for terminate and exhaust
                     if (ec == `CWE_EC_EXT || ec == `CWE_EC_INT)
                        sw_q <= {1'b0, ec, 1'b0, 16'h0, tal, 3'h0};
                     else
                        sw_q <= {1'b1, ec, db_q[`CWE_B_PAR], 16'h0,
                                 tal, cp};
                     st_q <= S_SCB;
                  end
               end else if (stop_q) begin
                  busy_q <= 1'b0;
                  st_q <= S_IDLE;
               end else if (fetch_q)
                  st_q <= S_LRA;
               else
                  st_q <= S_WAIT;
            S_SCB:
               if (!mem_req_o)
                  mop(1'b0, scw_q + {20'h0, ch_q, 1'b1}, 36'h0,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  sb_q <= mem_rdata_i;
                  st_q <= S_STW;
               end
            S_STW:
               if (!mem_req_o)
                  mop(1'b1, {6'h0, sb_q[`CWE_B_ADR]}, sw_q, `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= S_SWB;
               end
            S_SWB:
               if (!mem_req_o)
                  mop(1'b1, scw_q + {20'h0, ch_q, 1'b1},
                      {sb_q[`CWE_B_ADR] + 18'h1,
                       sb_q[`CWE_B_TAL] - 12'h001, sb_q[5:0]},
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= (sb_q[`CWE_B_TAL] == 12'h001) ? S_SCA : S_INT;
               end
            S_SCA:
               if (!mem_req_o)
                  mop(1'b0, scw_q + {20'h0, ch_q, 1'b0}, 36'h0,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  sb_q <= mem_rdata_i;
                  st_q <= (mem_rdata_i != 36'h0) ? S_SRP : S_INT;
               end
            S_SRP:
               if (!mem_req_o)
                  mop(1'b1, scw_q + {20'h0, ch_q, 1'b1}, sb_q,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= S_SZA;
               end
            S_SZA:
               if (!mem_req_o)
                  mop(1'b1, scw_q + {20'h0, ch_q, 1'b0}, 36'h0,
                      `CWE_ONES);
               else if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  st_q <= S_INT;
               end
            S_INT: begin
               intr_o <= 1'b1;
               intr_chan_o <= ch_q;
               st_q <= S_EVT;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // cwe_engine
`default_nettype wire

// >>> testbench/cwe_engine_checker.sv
// port assertions for the control word engine
`timescale 1ns/1ps
`default_nettype none
module cwe_engine_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        mem_req_o,
   input wire logic        mem_we_o,
   input wire logic [23:0] mem_addr_o,
   input wire logic [35:0] mem_mask_o,
   input wire logic        mem_ack_i,
   input wire logic        adp_strobe_o,
   input wire logic        list_act_o,
   input wire logic        end_xfer_o,
   input wire logic        intr_o,
   input wire logic [2:0]  intr_chan_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_req_hold;
      mem_req_o && !mem_ack_i && ce_i |=>
         mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("memory request changed before ack");
   property p_req_drop;
      mem_req_o && mem_ack_i && ce_i |=> !mem_req_o;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("memory request held after ack");
   property p_intr_chan;
      intr_o |-> intr_chan_o != 3'h0;
   endproperty
   a_intr_chan: assert property (p_intr_chan)
      else $error("interrupt on the emergency channel");
   property p_intr_pulse;
      intr_o && ce_i |=> !intr_o;
   endproperty
   a_intr_pulse: assert property (p_intr_pulse)
      else $error("interrupt longer than one cycle");
   property p_list_pulse;
      list_act_o && ce_i |=> !list_act_o;
   endproperty
   a_list_pulse: assert property (p_list_pulse)
      else $error("list activation longer than one cycle");
   property p_edt_pulse;
      end_xfer_o && ce_i |=> !end_xfer_o;
   endproperty
   a_edt_pulse: assert property (p_edt_pulse)
      else $error("end transfer longer than one cycle");
   // a partial write must cover exactly one 6-bit or 9-bit slot
   property p_mask_units;
      mem_req_o && mem_we_o && mem_mask_o != 36'hfffffffff |->
         $countones(mem_mask_o) == 6 || $countones(mem_mask_o) == 9;
   endproperty
   a_mask_units: assert property (p_mask_units)
      else $error("partial write mask is not one character");
   property p_strobe_ack;
      adp_strobe_o |-> $past(mem_ack_i) || $past(mem_ack_i, 2);
   endproperty
   a_strobe_ack: assert property (p_strobe_ack)
      else $error("unit strobe without a memory access");
   c_intr: cover property (intr_o);
   c_strobe: cover property (adp_strobe_o);
   c_list: cover property (list_act_o);
endmodule // cwe_engine_checker
bind cwe_engine cwe_engine_checker u_chk (.clk_i, .rst_i, .ce_i, .mem_req_o,
   .mem_we_o, .mem_addr_o, .mem_mask_o, .mem_ack_i, .adp_strobe_o,
   .list_act_o, .end_xfer_o, .intr_o, .intr_chan_o);
`default_nettype wire

// >>> testbench/cwe_mem_model.sv
// memory partner: masked word store with a latency set by the bench
`timescale 1ns/1ps
`default_nettype none
module cwe_mem_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  lat_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [35:0] wdata_i,
   input  wire logic [35:0] mask_i,
   output var  logic        ack_o,
   output wire logic [35:0] rdata_o
);
   logic [35:0] mem [0:255];
   logic [35:0] rd_q;
   logic [1:0]  cnt_q;
   // idle bus shows inverted data so a late sample never matches by luck
   assign rdata_o = ack_o ? rd_q : ~rd_q;
   initial begin
      rd_q = 36'h0;
      for (int i = 0; i < 256; i++) mem[i] = 36'h0;
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         ack_o <= 1'b0;
         if (req_i && !ack_o) begin
            if (cnt_q == lat_i) begin
               ack_o <= 1'b1;
               cnt_q <= 2'h0;
               rd_q <= mem[addr_i[7:0]];
               if (we_i) mem[addr_i[7:0]] <=
                  (mem[addr_i[7:0]] & ~mask_i) | (wdata_i & mask_i);
            end else cnt_q <= cnt_q + 2'h1;
         end
      end
   end
endmodule // cwe_mem_model
`default_nettype wire

// >>> testbench/tb_top.sv
// directed bench: an output run to exhaust, an input run to terminate
`timescale 1ns/1ps
`default_nettype none
`include "cwe_regs.vh"
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        we_i = 1'b0;
   logic        re_i = 1'b0;
   logic        svc_req_i = 1'b0;
   logic        adp_perr_i = 1'b0;
   logic        adp_term_i = 1'b0;
   logic        adp_ext_i = 1'b0;
   logic [1:0]  lat = 2'h0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] v;
   logic [35:0] adp_data_i = 36'h0;
   wire         mem_req_o, mem_we_o, mem_ack_i, adp_strobe_o, list_act_o;
   wire         end_xfer_o, cmd_o, lit_o, intr_o;
   wire [2:0]   intr_chan_o;
   wire [8:0]   cmd_data_o, lit_char_o;
   wire [23:0]  mem_addr_o;
   wire [31:0]  rdata_o;
   wire [35:0]  mem_wdata_o, mem_mask_o, mem_rdata_i, adp_data_o;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [35:0] lits = 36'h0;
   logic [35:0] edts = 36'h0;
   logic [35:0] acts = 36'h0;
   logic [8:0]  cmd_seen = 9'h0;
   logic [8:0]  lit_seen = 9'h0;
   logic [35:0] seen_q[$];
   logic [2:0]  chan_q[$];
   cwe_engine dut (.clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .we_i, .re_i,
      .rdata_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_mask_o,
      .mem_ack_i, .mem_rdata_i, .svc_req_i, .adp_data_i, .adp_perr_i,
      .adp_term_i, .adp_ext_i, .adp_data_o, .adp_strobe_o, .list_act_o,
      .end_xfer_o, .cmd_o, .cmd_data_o, .lit_o, .lit_char_o, .intr_o,
      .intr_chan_o);
   cwe_mem_model u_mem (.clk_i, .rst_i, .lat_i(lat), .req_i(mem_req_o),
      .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .mask_i(mem_mask_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (adp_strobe_o) seen_q.push_back(adp_data_o);
      if (intr_o) chan_q.push_back(intr_chan_o);
      if (list_act_o) acts++;
      if (end_xfer_o) edts++;
      if (cmd_o) cmd_seen = cmd_data_o;
      if (lit_o) begin
         lits++;
         lit_seen = lit_char_o;
      end
      if (cyc > 20000) begin
         fail_count++;
         final_report;
      end
   end
   task chk(input logic [35:0] s, input logic [35:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask
   // no completion flag for a whole service, so wait for a quiet bus
   task quiet;
      int n;
      int g;
      n = 0;
      g = 0;
      while (n < 12 && g < 400) begin
         @(negedge clk_i);
         g++;
         n = mem_req_o ? 0 : n + 1;
      end
      chk({35'h0, n >= 12}, 36'h1);
   endtask
   task svc(input logic [35:0] d, input logic perr);
      quiet;
      @(posedge clk_i);
      adp_data_i <= d;
      adp_perr_i <= perr;
      svc_req_i <= 1'b1;
      @(posedge clk_i);
      svc_req_i <= 1'b0;
      adp_perr_i <= 1'b0;
      quiet;
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #1;
      u_mem.mem[8'h11] = {18'h00020, 12'h001, 6'h00};
      u_mem.mem[8'h20] = 36'h010000000;
      u_mem.mem[8'h21] = {18'h00030, 12'h002, `CWE_S_W36, 4'h0};
      u_mem.mem[8'h30] = 36'h123456789;
      u_mem.mem[8'h31] = 36'hfedcba987;
      u_mem.mem[8'h43] = {18'h00070, 12'h004, 6'h00};
      u_mem.mem[8'h45] = {18'h00060, 12'h004, 6'h00};
      u_mem.mem[8'h47] = {18'h00080, 12'h004, 6'h00};
      u_mem.mem[8'h51] = {18'h00024, 12'h001, 6'h00};
      u_mem.mem[8'h24] = 36'h050600000;
      u_mem.mem[8'h25] = {18'h00038, 12'h005, `CWE_S_C9, 4'h0};
      u_mem.mem[8'h91] = {18'h000a0, 12'h002, 6'h00};
      u_mem.mem[8'ha0] = {3'h3, 15'h0, 9'h05a, 9'h000};
      u_mem.mem[8'ha2] = {3'h4, 14'h0, 1'b1, 9'h0c3, 9'h000};
      u_mem.mem[8'ha3] = {18'h00000, 12'h002, 6'h00};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h14);
      chk({4'h0, v}, 36'h0);
      wr(`CWE_R_MBX, 32'h10);
      wr(`CWE_R_SCW, 32'h40);
      wr(`CWE_R_CTRL, 32'h1);
      svc(36'h0, 1'b0);
      svc(36'h0, 1'b0);
      chk(seen_q[0], 36'h123456789);
      chk(seen_q[1], 36'hfedcba987);
      chk(u_mem.mem[8'h60], {1'b1, `CWE_EC_EXH, 32'h0});
      chk(u_mem.mem[8'h45], {18'h00061, 12'h003, 6'h00});
      chk({33'h0, chan_q[0]}, 36'h2);
      chk(u_mem.mem[8'h11], {18'h00022, 12'h000, 6'h00});
      rd(`CWE_R_STAT);
      chk({34'h0, v[1:0]}, 36'h2);
      chan_q.delete();
      lat <= 2'h3;
      wr(`CWE_R_MBX, 32'h50);
      wr(`CWE_R_CTRL, 32'h7);
      svc(36'h041, 1'b1);
      chk({27'h0, u_mem.mem[8'h38][35:27]}, 36'h041);
      chk(u_mem.mem[8'h53], {18'h00038, 12'h004, `CWE_S_C9, 4'h9});
      @(posedge clk_i);
      adp_term_i <= 1'b1;
      @(posedge clk_i);
      adp_term_i <= 1'b0;
      quiet;
      chk(u_mem.mem[8'h70], {5'h13, 16'h0, 12'h004, 3'h1});
      chk(u_mem.mem[8'h80],
          {1'b0, `CWE_EC_INT, 17'h0, 12'h004, 3'h0});
      chk({33'h0, chan_q[0]}, 36'h1);
      chk({33'h0, chan_q[1]}, 36'h3);
      rd(`CWE_R_STAT);
      chk({35'h0, v[2]}, 36'h1);
      rd(`CWE_R_CTRL);
      chk({4'h0, v}, 36'h3);
      // command word then a literal sent twice, ending on end-transfer
      wr(`CWE_R_MBX, 32'h90);
      wr(`CWE_R_CTRL, 32'h1);
      svc(36'h0, 1'b0);
      svc(36'h0, 1'b0);
      chk({27'h0, cmd_seen}, 36'h05a);
      chk(u_mem.mem[8'h92], {3'h3, 15'h0, 9'h05a, 9'h000});
      chk(lits, 36'h2);
      chk({27'h0, lit_seen}, 36'h0c3);
      chk(edts, 36'h1);
      chk(acts, 36'h1);
      final_report;
   end
endmodule // tb_top
`default_nettype wire
